// ---- inc/frac_prescaler_pkg.sv ----
// Purpose: Shared constants for the fractional baud prescaler.
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
// Notes: Control word is 16 bits wide; upper bus bits read as zero.
package frac_prescaler_pkg;
    // Register byte offsets.
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] MISC_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;
    localparam int ADDR_WIDTH = 4;
    // Fields of the fractional prescaler control word.
    localparam int SRC_SEL_BIT = 15;
    localparam int TAP_MSB = 10;
    localparam int TAP_LSB = 8;
    localparam int STEP_MSB = 7;
    localparam int STEP_LSB = 0;
    localparam logic [2:0] TAP_DISABLED = 3'h7;
    localparam logic [15:0] CTRL_RESET = 16'h0700;
    // Fields of the miscellaneous control word.
    localparam int BIT_CLK_SRC_BIT = 14;
    localparam int BAUD_CLEAR_BIT = 11;
    localparam logic [15:0] MISC_RESET = 16'h0000;
    // Fields of the status word.
    localparam int STAT_FRAC_ON_BIT = 0;
    localparam int STAT_PIN_BIT = 1;
    localparam int STAT_CNT_LSB = 8;
    // Accumulator arithmetic, counted in 1/128 input clocks.
    localparam int ACC_WIDTH = 16;
    localparam logic [15:0] ACC_STEP = 16'h0080;
    localparam logic [15:0] RANGE_BASE = 16'h0100;
    localparam int GAP_WIDTH = 12;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/frac_divider.sv ----
// Purpose: Accumulator-based non-integer clock divider producing an enable pulse.
// Assumes: Ratio is at least two, so pulses are never back to back.
// Notes: Any change of tap or step restarts the accumulator from zero.
`timescale 1ns/100ps
module frac_divider
    import frac_prescaler_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic [2:0] tap,
    input wire logic [7:0] step,
    output logic tick_reg
);
    logic [ACC_WIDTH-1:0] acc_reg;
    logic [ACC_WIDTH-1:0] limit;
    logic [ACC_WIDTH-1:0] acc_next;
    logic [10:0] cfg_reg;
    logic cfg_changed;
    logic enabled;
    logic [GAP_WIDTH-1:0] gap_reg;
    logic run_reg;

    // Limit is the whole ratio in 1/128 units: (256 + step) shifted by the tap.
    assign limit = (RANGE_BASE + {8'h00, step}) << tap;
    assign acc_next = acc_reg + ACC_STEP;
    assign enabled = (tap != TAP_DISABLED);
    assign cfg_changed = (cfg_reg != {tap, step});

    // Remember the setting so a rewrite cannot leave a stale, oversized remainder.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cfg_reg <= 11'h000;
        else
            cfg_reg <= {tap, step};
    end

    // The remainder carries over, so some periods are one clock longer.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear || !enabled || cfg_changed)
        begin
            acc_reg <= '0;
            tick_reg <= 1'b0;
        end
        else if (acc_next >= limit)
        begin
            acc_reg <= acc_next - limit;
            tick_reg <= 1'b1;
        end
        else
        begin
            acc_reg <= acc_next;
            tick_reg <= 1'b0;
        end
    end

    // Helper: clocks since the last pulse, valid once a full period has run.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear || !enabled || cfg_changed)
        begin
            gap_reg <= '0;
            run_reg <= 1'b0;
        end
        else if (tick_reg)
        begin
            gap_reg <= 12'h001;
            run_reg <= 1'b1;
        end
        else if (gap_reg != 12'hfff)
            gap_reg <= gap_reg + 12'h001;
    end

    a_clear_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        clear |=> !tick_reg && acc_reg == '0)
        else $error("Prescaler ran while its counters were held clear.");
    a_disable_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (tap == TAP_DISABLED) [*2] |-> !tick_reg)
        else $error("Prescaler pulsed while disabled.");
    a_period_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick_reg && run_reg && !cfg_changed) |->
        ({4'h0, gap_reg} << 7) + 23'd128 > {7'h00, limit} &&
        ({4'h0, gap_reg} << 7) < {7'h00, limit} + 23'd128)
        else $error("Output period is not the floor or ceiling of the ratio.");
    a_range_floor: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick_reg && run_reg && !cfg_changed) |->
        {4'h0, gap_reg} >= (16'h0002 << tap))
        else $error("Output period is below the range minimum.");
    a_no_double: assert property (@(posedge aclk) disable iff (!aresetn)
        tick_reg |=> !tick_reg)
        else $error("Prescaler pulsed on two adjacent clocks.");
endmodule

// ---- src/uart_fractional_baud_prescaler.sv ----
// Purpose: Fractional baud prescaler with source selects and AXI4-Lite registers.
// Assumes: Integer prescaler and baud divider tick on aclk, outside this block.
// Notes: The external bit clock pin is asynchronous and is resynchronised here.
// How it works
// - Bit 15 picks integer or fractional prescaler.
// - Tap code n: minimum 2^(n+1), step 2^(n-7).
// - Tap code all ones disables the prescaler.
// - Low byte is unsigned step count 0-255.
// - Ratio equals range minimum plus step times size.
// - Bit clock from generator or external pin.
// - Counter clear bit holds prescaler counters reset.
`timescale 1ns/100ps
module uart_fractional_baud_prescaler
    import frac_prescaler_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic integer_prescaler_tick,
    input wire logic baud_generator_tick,
    input wire logic external_bit_clock_pin,
    output logic divider_clock_en,
    output logic bit_clock_en,
    output logic baud_counter_clear
);
    logic [15:0] ctrl_reg;
    logic [15:0] misc_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rd_hit;
    logic wr_commit;
    logic div_en_reg;
    logic bit_en_reg;
    logic clear_reg;
    logic [2:0] pin_sync_reg;
    logic pin_level_reg;
    logic pin_rise;
    logic frac_tick;
    logic [7:0] tick_count_reg;
    logic src_sel;
    logic bit_src;
    logic clear_bit;

    assign src_sel = ctrl_reg[SRC_SEL_BIT];
    assign bit_src = misc_reg[BIT_CLK_SRC_BIT];
    assign clear_bit = misc_reg[BAUD_CLEAR_BIT];
    assign wr_commit = awready_reg && s_axi_awvalid && s_axi_wvalid;

    // Write channel: both address and data are taken on the same edge.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
        end
        else if (!awready_reg && !bvalid_reg && s_axi_awvalid && s_axi_wvalid)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
        end
        else
        begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
        end
    end

    // Write response stands until the master accepts it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else if (wr_commit)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (s_axi_awaddr == CTRL_OFFSET || s_axi_awaddr == MISC_OFFSET
                || s_axi_awaddr == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    // Control word: reserved bits 14-11 are not stored and read as zero.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_reg <= CTRL_RESET;
        else if (wr_commit && s_axi_awaddr == CTRL_OFFSET)
        begin
            if (s_axi_wstrb[0])
                ctrl_reg[STEP_MSB:STEP_LSB] <= s_axi_wdata[STEP_MSB:STEP_LSB];
            if (s_axi_wstrb[1])
            begin
                ctrl_reg[SRC_SEL_BIT] <= s_axi_wdata[SRC_SEL_BIT];
                ctrl_reg[TAP_MSB:TAP_LSB] <= s_axi_wdata[TAP_MSB:TAP_LSB];
            end
        end
    end

    // Miscellaneous word keeps only the bit clock source and counter clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            misc_reg <= MISC_RESET;
        else if (wr_commit && s_axi_awaddr == MISC_OFFSET && s_axi_wstrb[1])
        begin
            misc_reg[BIT_CLK_SRC_BIT] <= s_axi_wdata[BIT_CLK_SRC_BIT];
            misc_reg[BAUD_CLEAR_BIT] <= s_axi_wdata[BAUD_CLEAR_BIT];
        end
    end

    // Read data mux; the status word shows live prescaler state.
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            CTRL_OFFSET: rdata_next[15:0] = ctrl_reg;
            MISC_OFFSET: rdata_next[15:0] = misc_reg;
            STATUS_OFFSET:
            begin
                rdata_next[STAT_FRAC_ON_BIT] = (ctrl_reg[TAP_MSB:TAP_LSB] != TAP_DISABLED);
                rdata_next[STAT_PIN_BIT] = pin_level_reg;
                rdata_next[STAT_CNT_LSB +: 8] = tick_count_reg;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: one-cycle address accept, data held until taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end
        else
        begin
            arready_reg <= !arready_reg && !rvalid_reg && s_axi_arvalid;
            if (arready_reg && s_axi_arvalid)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rdata_next;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end

    // Pin resynchroniser; a level counts only once stages two and three agree.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_sync_reg <= 3'h0;
            pin_level_reg <= 1'b0;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[1:0], external_bit_clock_pin};
            if (pin_sync_reg[1] == pin_sync_reg[2])
                pin_level_reg <= pin_sync_reg[2];
        end
    end
    assign pin_rise = (pin_sync_reg[1] == pin_sync_reg[2]) && pin_sync_reg[2] && !pin_level_reg;

    frac_divider u_frac_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(clear_reg),
        .tap(ctrl_reg[TAP_MSB:TAP_LSB]),
        .step(ctrl_reg[STEP_MSB:STEP_LSB]),
        .tick_reg(frac_tick)
    );

    // Clock selects; registered so every output leaves a flip-flop.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_en_reg <= 1'b0;
            bit_en_reg <= 1'b0;
            clear_reg <= 1'b0;
        end
        else
        begin
            div_en_reg <= src_sel ? frac_tick : integer_prescaler_tick;
            bit_en_reg <= bit_src ? pin_rise : baud_generator_tick;
            clear_reg <= clear_bit;
        end
    end

    // Wrapping count of fractional pulses, held at zero by the counter clear, visible for debug.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear_reg)
            tick_count_reg <= 8'h00;
        else if (frac_tick)
            tick_count_reg <= tick_count_reg + 8'h01;
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign divider_clock_en = div_en_reg;
    assign bit_clock_en = bit_en_reg;
    assign baud_counter_clear = clear_reg;

    a_src_frac: assert property (@(posedge aclk) disable iff (!aresetn)
        src_sel |=> divider_clock_en == $past(frac_tick))
        else $error("Divider enable does not follow the fractional prescaler.");
    a_src_int: assert property (@(posedge aclk) disable iff (!aresetn)
        !src_sel |=> divider_clock_en == $past(integer_prescaler_tick))
        else $error("Divider enable does not follow the integer prescaler.");
    a_bitclk_gen: assert property (@(posedge aclk) disable iff (!aresetn)
        !bit_src && baud_generator_tick |=> bit_clock_en)
        else $error("Bit clock missed a baud generator pulse.");
    a_bitclk_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_src && !pin_level_reg ##1 (bit_src && pin_level_reg) |-> bit_clock_en)
        else $error("Bit clock missed a rising edge of the external pin.");
    // Four cycles: one to register the bit, one to clear the divider, one to drain the select.
    a_clear_path: assert property (@(posedge aclk) disable iff (!aresetn)
        (clear_bit && src_sel) [*4] |-> baud_counter_clear && !divider_clock_en)
        else $error("Counter clear did not reach the counters.");
    a_step_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_commit && s_axi_awaddr == CTRL_OFFSET && s_axi_wstrb[0]
        |=> ctrl_reg[STEP_MSB:STEP_LSB] == $past(s_axi_wdata[STEP_MSB:STEP_LSB]))
        else $error("Step count write was not stored.");
endmodule

// ---- sim/baud_partner_model.sv ----
// Purpose: Model of the integer prescaler and baud divider beside the block.
// Assumes: Prescaler counts aclk edges, divider counts divider_clock_en pulses; both give one-cycle ticks.
// Notes: Clear holds both counters at zero, like the real generator.
`timescale 1ns/100ps
module baud_partner_model #(
    parameter int INT_DIV = 5,
    parameter int BAUD_DIV = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic divider_clock_en,
    input wire logic baud_counter_clear,
    output logic integer_prescaler_tick,
    output logic baud_generator_tick
);
    int int_cnt_reg;
    int baud_cnt_reg;
    // Integer prescaler: free-running, one tick every INT_DIV clocks.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || baud_counter_clear)
            int_cnt_reg <= 0;
        else
            int_cnt_reg <= (int_cnt_reg == INT_DIV - 1) ? 0 : int_cnt_reg + 1;
        integer_prescaler_tick <= aresetn && !baud_counter_clear && int_cnt_reg == INT_DIV - 1;
    end
    // Divider counts only what the selected prescaler hands it.
    always_ff @(posedge aclk)
    begin
        baud_generator_tick <= 1'h0;
        if (!aresetn || baud_counter_clear)
            baud_cnt_reg <= 0;
        else if (divider_clock_en)
        begin
            baud_cnt_reg <= (baud_cnt_reg == BAUD_DIV - 1) ? 0 : baud_cnt_reg + 1;
            baud_generator_tick <= (baud_cnt_reg == BAUD_DIV - 1);
        end
    end
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the fractional baud prescaler.
// Assumes: Inputs change on rising edges; enable outputs are sampled on falling edges, AXI outputs on rising edges.
// Notes: Periods are summed over whole accumulator cycles, so sums are exact.
`timescale 1ns/100ps
module tb_top;
    import frac_prescaler_pkg::*;
    localparam int INT_DIV = 5;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_WIDTH-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, external_bit_clock_pin = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic integer_prescaler_tick, baud_generator_tick;
    logic divider_clock_en, bit_clock_en, baud_counter_clear;
    int err_count = 0;
    int checks = 0;
    int bit_total = 0;

    uart_fractional_baud_prescaler u_uart_fractional_baud_prescaler (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .integer_prescaler_tick(integer_prescaler_tick),
        .baud_generator_tick(baud_generator_tick),
        .external_bit_clock_pin(external_bit_clock_pin),
        .divider_clock_en(divider_clock_en), .bit_clock_en(bit_clock_en),
        .baud_counter_clear(baud_counter_clear));
    baud_partner_model #(.INT_DIV(INT_DIV), .BAUD_DIV(4)) u_baud_partner_model (
        .aclk(aclk), .aresetn(aresetn), .divider_clock_en(divider_clock_en),
        .baud_counter_clear(baud_counter_clear),
        .integer_prescaler_tick(integer_prescaler_tick),
        .baud_generator_tick(baud_generator_tick));

    // Clock at 40 MHz and a running tally of bit clock enables.
    always #12.5 aclk = ~aclk;
    always @(negedge aclk)
        bit_total += bit_clock_en;

    task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
        checks++;
        if (got !== expv)
        begin
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
            err_count++;
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic timeout(input string what);
        $display("[FAIL] %s expected answer seen timeout", what);
        err_count++;
        complete_run();
    endtask

    // Address and data go out together; each is dropped once its ready is seen.
    task automatic axi_write(input logic [3:0] addr, input logic [15:0] data,
                             input logic [1:0] resp);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= {16'h0000, data};
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (n > 200)
                timeout("write");
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
    endtask

    // The mask hides status bits whose value the bench cannot predict.
    task automatic axi_read(input logic [3:0] addr, input logic [31:0] expv,
                            input logic [31:0] mask, input logic [1:0] resp);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (n > 200)
                timeout("read");
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk("rdata", expv, s_axi_rdata & mask);
        chk("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
    endtask

    task automatic wait_div();
        int n = 0;
        do
        begin
            @(negedge aclk);
            n++;
            if (n > 3000)
                timeout("divider_clock_en");
        end
        while (!divider_clock_en);
    endtask

    // Skips the restart period and one more period, then sums k whole periods.
    task automatic measure(input int k, input int expv, input string what);
        int cyc = 0;
        int got = 0;
        wait_div();
        wait_div();
        while (got < k && cyc < 4000)
        begin
            @(negedge aclk);
            cyc++;
            got += divider_clock_en;
        end
        if (got < k)
            timeout(what);
        chk(what, expv, cyc);
    endtask

    task automatic count_div(input int cyc, input int expv, input string what);
        int n = 0;
        repeat (cyc)
        begin
            @(negedge aclk);
            n += divider_clock_en;
        end
        chk(what, expv, n);
    endtask

    task automatic test_reset();
        axi_read(CTRL_OFFSET, 32'h0000_0700, 32'hffff_ffff, RESP_OKAY);
        axi_read(MISC_OFFSET, 32'h0000_0000, 32'hffff_ffff, RESP_OKAY);
        axi_read(4'hc, 32'h0000_0000, 32'hffff_ffff, RESP_SLVERR);
        axi_write(4'hc, 16'hffff, RESP_SLVERR);
        // Low byte strobe only, so the upper byte must keep its reset value.
        s_axi_wstrb <= 4'h1;
        axi_write(CTRL_OFFSET, 16'h86a5, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_read(CTRL_OFFSET, 32'h0000_07a5, 32'hffff_ffff, RESP_OKAY);
        measure(4, 4 * INT_DIV, "integer period");
        $display("Test reset done");
    endtask

    // Eight entries for tap codes 0 to 6, tap 0 twice; the tap 1 step is rounded as software would.
    task automatic test_fraction();
        logic [2:0] taps [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
        logic [7:0] steps [8] = '{8'h00, 8'hff, 8'h00, 8'h01, 8'h80, 8'hfe, 8'h07, 8'hff};
        steps[2] = 8'(int'((5.397333 - 4.0) * 64.0));
        for (int i = 0; i < 8; i++)
        begin
            axi_write(CTRL_OFFSET, {1'h1, 4'h0, taps[i], steps[i]}, RESP_OKAY);
            measure(128 >> taps[i], 256 + steps[i], "fraction period");
        end
        axi_read(STATUS_OFFSET, 32'h0000_0001, 32'h0000_0003, RESP_OKAY);
        $display("Test fraction done");
    endtask

    task automatic test_disable();
        axi_write(CTRL_OFFSET, 16'h8700, RESP_OKAY);
        repeat (20) @(posedge aclk);
        count_div(600, 0, "ticks while disabled");
        axi_write(CTRL_OFFSET, 16'h0700, RESP_OKAY);
        measure(4, 4 * INT_DIV, "integer period back");
        $display("Test disable done");
    endtask

    task automatic test_clear();
        axi_write(CTRL_OFFSET, 16'h8000, RESP_OKAY);
        axi_write(MISC_OFFSET, 16'h0800, RESP_OKAY);
        @(negedge aclk);
        chk("counter clear", 1, baud_counter_clear);
        // A tick launched before the clear landed may still be in flight.
        repeat (2) @(posedge aclk);
        count_div(200, 0, "ticks while cleared");
        axi_read(STATUS_OFFSET, 32'h0000_0001, 32'hffff_ffff, RESP_OKAY);
        axi_write(MISC_OFFSET, 16'h0000, RESP_OKAY);
        measure(128, 256, "period after clear");
        $display("Test clear done");
    endtask

    // Generator ticks reach the bit clock until the pin is chosen.
    task automatic test_bit_clock();
        int start;
        // Tally is read on rising edges only, away from the falling-edge update.
        @(posedge aclk);
        start = bit_total;
        repeat (400) @(posedge aclk);
        chk("generator bit clocks", 50, bit_total - start);
        axi_write(MISC_OFFSET, 16'h4000, RESP_OKAY);
        repeat (10) @(posedge aclk);
        start = bit_total;
        repeat (6)
        begin
            repeat (10) @(posedge aclk);
            external_bit_clock_pin <= 1'h1;
            repeat (10) @(posedge aclk);
            external_bit_clock_pin <= 1'h0;
        end
        repeat (10) @(posedge aclk);
        chk("pin bit clocks", 6, bit_total - start);
        external_bit_clock_pin <= 1'h1;
        repeat (10) @(posedge aclk);
        axi_read(STATUS_OFFSET, 32'h0000_0003, 32'h0000_0003, RESP_OKAY);
        $display("Test bit clock done");
    endtask

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        test_reset();
        test_fraction();
        test_disable();
        test_clear();
        test_bit_clock();
        complete_run();
    end
endmodule
